// ### rtl/eft_timing_top.sv
`timescale 1ns/100ps
// Operation
// - Format 0 expanded link, 1 base link
// - Compression on with 12-bit depth maps 16-bit samples to 12
// - Frame interval zero means fastest allowed
// - Region sizes match binning, width by 16
// - Large: 2560x2160, even column, vertically centred, even height
// - Small: 1920x1080, shared rules only
// - Rolling reset pointer sweeps rows before readout
// - Exposure and interval kept in row times
// - Minimum interval: height, or twice height+17
// - Internal maximum interval: 262143-based limits
// - External interval below 262143 plus height
// - Exposure from 1 to shutter-dependent maximum
// - Timing settable only while stopped
// - Microseconds rounded to nearest row time
// - Row time 2624 or 2464 sensor clocks
// - Large sensor uses half height for timing
module eft_timing_top import eft_pkg::*; #(
   parameter bit LARGE_SENSOR = 1'b1
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sclkIn,
   input wire logic trigIn,
   input wire logic [15:0] pixIn,
   input wire logic pixInValid,
   output logic captureActive,
   output logic linkBase,
   output logic [1:0] pixelDepth,
   output logic rowStart,
   output logic frameStart,
   output logic readValid,
   output logic [11:0] readRow,
   output logic resetValid,
   output logic [11:0] resetRow,
   output logic globalReset,
   output logic pixOutValid,
   output logic [15:0] pixOut
);
   localparam logic [11:0] ROW_CYC = LARGE_SENSOR ? ROW_CYC_LARGE : ROW_CYC_SMALL;
   localparam logic [11:0] MAX_W = LARGE_SENSOR ? MAXW_LARGE : MAXW_SMALL;
   localparam logic [11:0] MAX_H = LARGE_SENSOR ? MAXH_LARGE : MAXH_SMALL;

   // ==========================================
   // Reset release and pin synchronisers
   logic rstS1, rstn;
   logic sclkS1, sclkS2, sclkS3, trigS1, trigS2, trigS3;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstS1 <= 1'b0;
         rstn <= 1'b0;
      end else begin
         rstS1 <= 1'b1;
         rstn <= rstS1;
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {sclkS1, sclkS2, sclkS3} <= 3'h0;
         {trigS1, trigS2, trigS3} <= 3'h0;
      end else begin
         {sclkS1, sclkS2, sclkS3} <= {sclkIn, sclkS1, sclkS2};
         {trigS1, trigS2, trigS3} <= {trigIn, trigS1, trigS2};
      end
   end
   wire sclkEdge = sclkS2 & ~sclkS3;
   wire trigEdge = trigS2 & ~trigS3;

   // ==========================================
   // Registers and derived limits
   logic [31:0] ctrlReg, usReg;
   logic [11:0] colStg, wStg, rowStg, hStg, roiCol, roiW, roiRow, roiH;
   logic [3:0] binStg, binReg;
   logic [19:0] frameRowsReg, expRowsReg;
   logic activeReg, frameRej, expRej, roiRej, isFrame;
   eft_cfg_state_t cfgSt;
   wire glob = ctrlReg[B_GLOB];
   wire ext = ctrlReg[B_EXT];
   wire [11:0] hEff = LARGE_SENSOR ? {1'b0, roiH[11:1]} : roiH;
   wire [19:0] hE20 = {8'h00, hEff};
   wire [19:0] minFrame = glob ? ((hE20 + GUARD_ROWS) << 1) : hE20;
   logic [19:0] maxFrame;
   always_comb begin
      if (ext) maxFrame = SPAN_ROWS + hE20 - 20'h00001;
      else if (glob) maxFrame = (hE20 + SPAN_ROWS) << 1;
      else maxFrame = SPAN_ROWS + hE20;
   end
   // Underflow in bit 20 means no exposure fits the interval
   wire [20:0] expMax = glob ? {1'b0, frameRowsReg} - {1'b0, hE20 + GUARD_ROWS}
                             : {1'b0, frameRowsReg} - 21'h000001;

   // ==========================================
   // Bus slave
   logic [5:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   wire wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire mapped = (awAddr <= A_EROWS) && (awAddr[1:0] == 2'h0);
   wire cfgIdle = (cfgSt == ST_IDLE);
   wire wrCtrl = wrFire && awAddr == A_CTRL && !activeReg;
   wire wrCmd = wrFire && awAddr == A_CMD;
   wire doStart = wrCmd && wData[C_START] && !activeReg && cfgIdle;
   wire doStop = wrCmd && wData[C_STOP];
   wire doRoi = wrCmd && wData[C_ROI] && !activeReg && cfgIdle;
   wire wrTime = wrFire && (awAddr == A_FRAME || awAddr == A_EXP)
                 && !activeReg && cfgIdle;
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) o[b*8 +: 8] = n[b*8 +: 8];
      end
      return o;
   endfunction
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awAddr <= 6'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic [31:0] rdMux;
   always_comb begin
      unique case (s_axi_araddr)
         A_CTRL: rdMux = ctrlReg;
         A_FRAME, A_EXP: rdMux = usReg;
         A_COL: rdMux = {4'h0, roiW, 4'h0, roiCol};
         A_ROW: rdMux = {4'h0, roiH, 4'h0, roiRow};
         A_BIN: rdMux = {28'h0000000, binReg};
         A_STAT: rdMux = {27'h0000000, !cfgIdle, roiRej, expRej, frameRej, activeReg};
         A_FROWS: rdMux = {12'h000, frameRowsReg};
         A_EROWS: rdMux = {12'h000, expRowsReg};
         default: rdMux = 32'h00000000;
      endcase
   end
   wire rdMapped = (s_axi_araddr <= A_EROWS) && (s_axi_araddr[1:0] == 2'h0)
                   && (s_axi_araddr != A_CMD);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMapped ? rdMux : 32'h00000000;
         s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==========================================
   // Mode control and capture state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlReg <= CTRL_RST;
         activeReg <= 1'b0;
      end else begin
         if (wrCtrl) ctrlReg <= merge(ctrlReg, wData, wStrb);
         if (doStart) activeReg <= 1'b1;
         else if (doStop) activeReg <= 1'b0;
      end
   end
   assign captureActive = activeReg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         linkBase <= 1'b0;
         pixelDepth <= DEPTH_8;
      end else begin
         linkBase <= ctrlReg[B_FMT];
         pixelDepth <= ctrlReg[B_DEPTH +: 2];
      end
   end

   // ==========================================
   // Region staging and check
   wire [11:0] hMask = (12'h001 << binStg[1:0]) - 12'h001;
   wire [11:0] vMask = (12'h001 << binStg[3:2]) - 12'h001;
   wire [12:0] colEnd = {1'b0, colStg} + {1'b0, wStg};
   wire [12:0] rowEnd = {1'b0, rowStg} + {1'b0, hStg};
   wire roiBase = hStg != 12'h000 && wStg != 12'h000 && (hStg & vMask) == 12'h000
                  && (wStg & (hMask | ROI_W_ALIGN)) == 12'h000
                  && colEnd <= {1'b0, MAX_W} && rowEnd <= {1'b0, MAX_H};
   wire roiLarge = !colStg[0] && !hStg[0]
                   && ({rowStg, 1'b0} + {1'b0, hStg}) == {1'b0, MAX_H};
   wire roiOk = roiBase && (!LARGE_SENSOR || roiLarge);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {colStg, rowStg, roiCol, roiRow} <= 48'h0;
         {wStg, roiW} <= {ROI_RST_W, ROI_RST_W};
         hStg <= LARGE_SENSOR ? MAX_H : ROI_RST_H;
         roiH <= LARGE_SENSOR ? MAX_H : ROI_RST_H;
         {binStg, binReg} <= 8'h00;
         roiRej <= 1'b0;
      end else begin
         if (wrFire && awAddr == A_COL) {wStg, colStg} <= {wData[27:16], wData[11:0]};
         if (wrFire && awAddr == A_ROW) {hStg, rowStg} <= {wData[27:16], wData[11:0]};
         if (wrFire && awAddr == A_BIN) binStg <= wData[3:0];
         if (doRoi) begin
            roiRej <= !roiOk;
            if (roiOk) {roiCol, roiW, roiRow, roiH, binReg} <= {colStg, wStg, rowStg, hStg, binStg};
         end
      end
   end

   // ==========================================
   // Time conversion and limit check
   // Serial divider keeps area small; a setting takes 43 cycles to land
   logic [40:0] numReg, quoReg;
   logic [12:0] remReg;
   logic [5:0] bitCnt;
   wire [12:0] remShift = {remReg[11:0], numReg[40]};
   wire remGe = remShift >= {1'b0, ROW_CYC};
   wire [19:0] rowsCalc = (|quoReg[40:20]) ? 20'hfffff : quoReg[19:0];
   wire [19:0] frameReq = (rowsCalc == 20'h00000) ? minFrame : rowsCalc;
   wire frameOk = frameReq >= minFrame && frameReq <= maxFrame;
   wire expOk = rowsCalc != 20'h00000 && !expMax[20]
                && {1'b0, rowsCalc} <= expMax;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfgSt <= ST_IDLE;
         {numReg, quoReg} <= 82'h0;
         remReg <= 13'h0000;
         bitCnt <= 6'h00;
         usReg <= 32'h00000000;
         isFrame <= 1'b0;
         frameRowsReg <= FRAME_RST;
         expRowsReg <= EXP_RST;
         {frameRej, expRej} <= 2'h0;
      end else begin
         unique case (cfgSt)
            ST_IDLE: if (wrTime) begin
               usReg <= wData;
               isFrame <= awAddr == A_FRAME;
               numReg <= 41'(wData) * 41'(ctrlReg[B_MHZ +: 8])
                         + 41'(ROW_CYC >> 1);
               remReg <= 13'h0000;
               quoReg <= 41'h0;
               bitCnt <= 6'h00;
               cfgSt <= ST_DIV;
            end
            ST_DIV: begin
               remReg <= remGe ? remShift - {1'b0, ROW_CYC} : remShift;
               quoReg <= {quoReg[39:0], remGe};
               numReg <= {numReg[39:0], 1'b0};
               bitCnt <= bitCnt + 6'h01;
               if (bitCnt == 6'h28) cfgSt <= ST_CHK;
            end
            ST_CHK: begin
               if (isFrame) begin
                  frameRej <= !frameOk;
                  if (frameOk) frameRowsReg <= frameReq;
               end else begin
                  expRej <= !expOk;
                  if (expOk) expRowsReg <= rowsCalc;
               end
               cfgSt <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Row timing from the sensor clock
   logic [11:0] sclkCnt;
   logic [19:0] pos;
   logic rowTick, trigPend;
   wire [20:0] rpSum = {1'b0, pos} + {1'b0, expRowsReg};
   wire [20:0] rpMod = (rpSum >= {1'b0, frameRowsReg}) ? rpSum - {1'b0, frameRowsReg} : rpSum;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclkCnt <= 12'h000;
         rowTick <= 1'b0;
      end else begin
         rowTick <= 1'b0;
         if (!activeReg) sclkCnt <= 12'h000;
         else if (sclkEdge) begin
            if (sclkCnt == ROW_CYC - 12'h001) begin
               sclkCnt <= 12'h000;
               rowTick <= 1'b1;
            end else sclkCnt <= sclkCnt + 12'h001;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pos <= 20'h00000;
         trigPend <= 1'b0;
      end else begin
         if (trigEdge && activeReg) trigPend <= 1'b1;
         else if (rowTick) trigPend <= 1'b0;
         if (!activeReg) pos <= 20'h00000;
         else if (rowTick) begin
            if (ext) pos <= trigPend ? 20'h00000
                           : (pos < maxFrame ? pos + 20'h00001 : pos);
            else pos <= (pos >= frameRowsReg - 20'h00001) ? 20'h00000
                        : pos + 20'h00001;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {rowStart, frameStart, readValid, resetValid, globalReset} <= 5'h00;
         readRow <= 12'h000;
         resetRow <= 12'h000;
      end else begin
         rowStart <= rowTick;
         frameStart <= rowTick && pos == 20'h00000;
         readValid <= rowTick && pos < hE20;
         readRow <= pos[11:0];
         resetValid <= rowTick && !glob && rpMod < {1'b0, hE20};
         resetRow <= rpMod[11:0];
         globalReset <= rowTick && glob && pos == frameRowsReg - expRowsReg;
      end
   end

   // ==========================================
   // Pixel output path
   eft_pix_if pif ();
   logic [15:0] pixDly;
   assign pif.valid = pixInValid;
   assign pif.sample = pixIn;
   eft_sqrt u_sqrt (
      .clk(sys_clk),
      .rstn(rstn),
      .pif(pif)
   );
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pixDly <= 16'h0000;
         pixOut <= 16'h0000;
         pixOutValid <= 1'b0;
      end else begin
         pixDly <= pixIn;
         pixOutValid <= pif.resValid;
         if (pixelDepth == DEPTH_12 && ctrlReg[B_SQRT]) pixOut <= {4'h0, pif.result};
         else if (pixelDepth == DEPTH_12) pixOut <= {4'h0, pixDly[15:4]};
         else if (pixelDepth == DEPTH_8) pixOut <= {8'h00, pixDly[15:8]};
         else pixOut <= pixDly;
      end
   end

   // ==========================================
   // Checks
   property p_start;
      @(posedge sys_clk) disable iff (!rstn) doStart |=> captureActive [*2];
   endproperty
   a_start: assert property (p_start) else $error("start not held active");
   property p_lock;
      @(posedge sys_clk) disable iff (!rstn)
         activeReg |=> $stable(frameRowsReg) && $stable(expRowsReg);
   endproperty
   a_lock: assert property (p_lock) else $error("timing changed while active");
   property p_fast;
      @(posedge sys_clk) disable iff (!rstn)
         (cfgSt == ST_CHK && isFrame && rowsCalc == 20'h00000 && frameOk)
            |=> frameRowsReg == $past(minFrame);
   endproperty
   a_fast: assert property (p_fast) else $error("zero interval not minimum");
   property p_keep;
      @(posedge sys_clk) disable iff (!rstn)
         (cfgSt == ST_CHK && (isFrame ? !frameOk : !expOk))
            |=> $stable(frameRowsReg) && $stable(expRowsReg) && (frameRej || expRej);
   endproperty
   a_keep: assert property (p_keep) else $error("bad setting took effect");
   property p_exp;
      @(posedge sys_clk) disable iff (!rstn)
         $changed(expRowsReg) |-> expRowsReg != 20'h00000 && expRowsReg < frameRowsReg;
   endproperty
   a_exp: assert property (p_exp) else $error("exposure out of range");
   property p_row;
      @(posedge sys_clk) disable iff (!rstn) rowTick |=> !rowTick [*8];
   endproperty
   a_row: assert property (p_row) else $error("row time too short");
   property p_sweep;
      @(posedge sys_clk) disable iff (!rstn) resetValid |-> resetRow < hEff && !glob;
   endproperty
   a_sweep: assert property (p_sweep) else $error("reset row outside region");
   property p_width;
      @(posedge sys_clk) disable iff (!rstn)
         doRoi && roiOk |=> roiW[3:0] == 4'h0 && (roiH & vMask) == 12'h000;
   endproperty
   a_width: assert property (p_width) else $error("region alignment broken");
   property p_div;
      @(posedge sys_clk) disable iff (!rstn) wrTime |=> cfgSt == ST_DIV [*8];
   endproperty
   a_div: assert property (p_div) else $error("conversion cut short");
   property p_sqrt;
      @(posedge sys_clk) disable iff (!rstn)
         pixOutValid && pixelDepth == DEPTH_12 |-> pixOut[15:12] == 4'h0;
   endproperty
   a_sqrt: assert property (p_sqrt) else $error("12-bit output too wide");
endmodule // eft_timing_top

// ### rtl/eft_pkg.sv
package eft_pkg;
   // ==========================================
   // Register map
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_CMD = 6'h04;
   localparam logic [5:0] A_FRAME = 6'h08;
   localparam logic [5:0] A_EXP = 6'h0c;
   localparam logic [5:0] A_COL = 6'h10;
   localparam logic [5:0] A_ROW = 6'h14;
   localparam logic [5:0] A_BIN = 6'h18;
   localparam logic [5:0] A_STAT = 6'h1c;
   localparam logic [5:0] A_FROWS = 6'h20;
   localparam logic [5:0] A_EROWS = 6'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================
   // Fields and reset values
   localparam int B_FMT = 0;
   localparam int B_DEPTH = 1;
   localparam int B_SQRT = 3;
   localparam int B_GLOB = 4;
   localparam int B_EXT = 5;
   localparam int B_MHZ = 8;
   localparam int C_START = 0;
   localparam int C_STOP = 1;
   localparam int C_ROI = 2;
   localparam logic [31:0] CTRL_RST = 32'h0000c800;
   localparam logic [1:0] DEPTH_8 = 2'h0;
   localparam logic [1:0] DEPTH_16 = 2'h1;
   localparam logic [1:0] DEPTH_12 = 2'h2;
   // ==========================================
   // Sensor geometry and timing
   localparam logic [11:0] ROW_CYC_LARGE = 12'ha40;
   localparam logic [11:0] ROW_CYC_SMALL = 12'h9a0;
   localparam logic [11:0] MAXW_LARGE = 12'ha00;
   localparam logic [11:0] MAXH_LARGE = 12'h870;
   localparam logic [11:0] MAXW_SMALL = 12'h780;
   localparam logic [11:0] MAXH_SMALL = 12'h438;
   localparam logic [11:0] ROI_W_ALIGN = 12'h00f;
   localparam logic [19:0] GUARD_ROWS = 20'h00011;
   localparam logic [19:0] SPAN_ROWS = 20'h3ffff;
   localparam logic [11:0] ROI_RST_W = 12'h100;
   localparam logic [11:0] ROI_RST_H = 12'h100;
   localparam logic [19:0] FRAME_RST = 20'h00400;
   localparam logic [19:0] EXP_RST = 20'h00010;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DIV = 3'b010,
      ST_CHK = 3'b100
   } eft_cfg_state_t;
endpackage

// ### rtl/eft_pix_if.sv
`timescale 1ns/100ps
interface eft_pix_if;
   logic valid;
   logic [15:0] sample;
   logic resValid;
   logic [11:0] result;
   modport src (output valid, sample, input resValid, result);
   modport sink (input valid, sample, output resValid, result);
endinterface

// ### rtl/eft_sqrt.sv
`timescale 1ns/100ps
module eft_sqrt (
   input wire logic clk,
   input wire logic rstn,
   eft_pix_if.sink pif
);
   // ==========================================
   // Root of sample scaled by 256: 16 bits in, 12 bits out
   function automatic logic [11:0] isqrt(input logic [23:0] v);
      logic [11:0] q;
      logic [11:0] c;
      q = 12'h000;
      for (int i = 11; i >= 0; i--) begin
         c = q | (12'h001 << i);
         if (24'(c) * 24'(c) <= v) begin
            q = c;
         end
      end
      return q;
   endfunction

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pif.resValid <= 1'b0;
         pif.result <= 12'h000;
      end else begin
         pif.resValid <= pif.valid;
         pif.result <= isqrt({pif.sample, 8'h00});
      end
   end
endmodule // eft_sqrt

// ### verif/eft_sensor_model.sv
`timescale 1ns/100ps
// ==========================================
// Sensor side: free running clock, idle trigger
module eft_sensor_model (
   output logic sclk,
   output logic trig
);
   initial begin
      sclk = 1'b0;
      trig = 1'b0; // Internal trigger only, no interval from outside
      #37;
      // Slow clock so the pin synchroniser on sys_clk catches every edge
      forever #100 sclk = ~sclk;
   end
endmodule // eft_sensor_model

// ### verif/testbench.sv
`timescale 1ns/100ps
module testbench import eft_pkg::*; ();
   // ==========================================
   // Signals
   logic sys_clk = 1'b0, resetn = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv, fr, ex;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pixInValid = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, pixelDepth, rsp;
   logic sclkIn, trigIn, captureActive, linkBase, rowStart, pixOutValid;
   logic frameStart, readValid, resetValid, globalReset;
   logic [11:0] readRow, resetRow;
   logic [15:0] pixIn = 16'h0, pixOut;
   int failCount = 0, testsRun = 0;
   always #12.5 sys_clk = ~sys_clk;
   eft_sensor_model u_sensor (.sclk(sclkIn), .trig(trigIn));
   eft_timing_top u_dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclkIn, .trigIn, .pixIn,
      .pixInValid, .captureActive, .linkBase, .pixelDepth, .rowStart, .frameStart,
      .readValid, .readRow, .resetValid, .resetRow, .globalReset, .pixOutValid,
      .pixOut);
   // ==========================================
   // Checking and bus tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task results;
      $display("tests=%0d fails=%0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task lim(input bit hit);
      if (hit) begin
         failCount++;
         results;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 300);
      s_axi_bready <= 1'b0;
      lim(n >= 300);
   endtask
   task automatic rd(input logic [5:0] a);
      int n;
      n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 300);
      s_axi_rready <= 1'b0;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      lim(n >= 300);
   endtask
   // Conversion takes tens of cycles, so poll busy rather than guess
   task automatic cfg(input logic [5:0] a, input logic [31:0] d);
      int n;
      wr(a, d);
      rdv = 32'h10;
      for (n = 0; n < 100 && rdv[4]; n++) rd(A_STAT);
      lim(n >= 100);
   endtask
   task automatic waitRow(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rowStart !== 1'b1 && n < 30000);
      lim(n >= 30000);
   endtask
   function automatic logic [31:0] rows(input logic [31:0] us);
      return 32'((64'(us) * 200 + 1312) / 2624);
   endfunction
   function automatic logic [15:0] pexp(input logic [15:0] p, input int m);
      int v, r, t;
      v = int'(p) * 256;
      r = 0;
      for (int b = 11; b >= 0; b--) begin
         t = r | (1 << b);
         if (t * t <= v) r = t;
      end
      case (m)
         0: return {8'h0, p[15:8]};
         1: return p;
         2: return {4'h0, p[15:4]};
         default: return 16'(r);
      endcase
   endfunction
   // ==========================================
   // Main sequence
   initial begin
      logic [1:0] dp;
      int n;
      void'($urandom(32'h1b444eed));
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(A_CTRL);
      chk(rdv, CTRL_RST);
      rd(A_FROWS);
      chk(rdv, 32'(FRAME_RST));
      rd(6'h28);
      chk(32'(rsp), 32'(RESP_SLVERR));
      $display("end reset");
      for (int m = 0; m < 4; m++) begin
         dp = (m == 3) ? DEPTH_12 : 2'(m);
         wr(A_CTRL, CTRL_RST | 32'(m[0]) | (32'(dp) << B_DEPTH) | (32'(m == 3) << B_SQRT));
         repeat (2) @(posedge sys_clk);
         chk(32'(linkBase), 32'(m[0]));
         chk(32'(pixelDepth), 32'(dp));
         for (int k = 0; k < 2; k++) begin
            pixIn <= k ? 16'hffff : 16'($urandom);
            pixInValid <= 1'b1;
            repeat (4) @(posedge sys_clk);
            chk({15'h0, pixOutValid, pixOut}, {16'h1, pexp(pixIn, m)});
         end
         pixInValid <= 1'b0;
      end
      wr(A_CTRL, CTRL_RST | (32'h1 << B_GLOB)); // Compression off on leaving
      cfg(A_FRAME, 32'd0);
      rd(A_FROWS);
      chk(rdv, 32'd2194);
      wr(A_CTRL, CTRL_RST);
      $display("end modes");
      cfg(A_FRAME, 32'd0);
      rd(A_FROWS);
      chk(rdv, 32'd1080);
      fr = 32'd14432 + $urandom % 20000;
      cfg(A_FRAME, fr);
      rd(A_FROWS);
      chk(rdv, rows(fr));
      fr = rdv;
      cfg(A_FRAME, 32'd1000);
      chk(32'(rdv[1]), 32'd1);
      rd(A_FROWS);
      chk(rdv, fr);
      $display("end frame");
      n = 13 + $urandom % 400;
      ex = rows(32'(n));
      cfg(A_EXP, 32'(n)); // Interval already long enough
      rd(A_EROWS);
      chk(rdv, ex);
      cfg(A_EXP, 32'd0);
      chk(32'(rdv[2]), 32'd1);
      cfg(A_EXP, 32'd1000000);
      chk(32'(rdv[2]), 32'd1);
      wr(A_COL, 32'h01080000);
      cfg(A_CMD, 32'h4);
      chk(32'(rdv[3]), 32'd1);
      wr(A_COL, 32'h01000002);
      wr(A_ROW, 32'h04000237);
      cfg(A_CMD, 32'h4);
      chk(32'(rdv[3]), 32'd1);
      wr(A_ROW, 32'h04000238);
      cfg(A_CMD, 32'h4);
      chk(32'(rdv[3]), 32'd0);
      rd(A_ROW);
      chk(rdv, 32'h04000238);
      $display("end limits");
      cfg(A_CMD, 32'h1);
      chk(32'(captureActive), 32'd1);
      cfg(A_FRAME, 32'd30000);
      rd(A_FROWS);
      chk(rdv, fr);
      waitRow(n);
      chk({28'h0, frameStart, readValid, resetValid, globalReset}, 32'he);
      chk({8'h0, readRow, resetRow}, {20'h0, ex[11:0]});
      waitRow(n);
      chk({28'h0, frameStart, readValid, resetValid, globalReset}, 32'h6);
      chk({8'h0, readRow, resetRow}, {8'h0, 12'h001, ex[11:0] + 12'h001});
      chk(32'(n), 32'd20992);
      cfg(A_CMD, 32'h2);
      chk(32'(captureActive), 32'd0);
      $display("end capture");
      results;
   end
endmodule // testbench
